/* File: design/stp_top.sv */
// Purpose: shared prescaler and clock select for three timer units
// Assumes: AHB-Lite slave, single word transfers, 10 MHz clk
// Notes: timer_tick is a one-cycle count enable per timer
//
// The register offsets and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "stp_params.svh"

module stp_top
  import stp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [`STP_NUM_TIMERS-1:0] external_count_pin,
  output logic [`STP_NUM_TIMERS-1:0] timer_tick,
  output logic timer0_divider_reset
);

  stp_top_s s_reg;
  stp_top_s s_next;

  logic [`STP_NUM_TAPS-1:0] tap;
  logic [`STP_DIV_W-1:0] div_count;
  logic [`STP_NUM_TIMERS-1:0] ext_rise;
  logic [`STP_NUM_TIMERS-1:0] ext_fall;
  logic [`STP_NUM_TIMERS-1:0] tick_next;
  logic addr_ok;

  stp_divider u_divider (
    .clk(clk),
    .rst(rst),
    .clear(s_reg.sh_rst),
    .tap(tap),
    .count(div_count)
  );

  // Each timer owns its pin and its decode; only the divider is shared
  genvar gi;
  generate
    for (gi = 0; gi < `STP_NUM_TIMERS; gi++) begin : g_timer
      stp_cs_e cs;

      stp_ext_sync u_sync (
        .clk(clk),
        .rst(rst),
        .pin(external_count_pin[gi]),
        .rise(ext_rise[gi]),
        .fall(ext_fall[gi])
      );

      always_comb begin
        cs = stp_cs_e'(s_reg.csel[gi*`STP_CS_W +: `STP_CS_W]);
        unique case (cs)
          STP_CS_OFF: tick_next[gi] = 1'b0;
          STP_CS_SYS: tick_next[gi] = 1'b1;
          STP_CS_DIV8: tick_next[gi] = tap[0];
          STP_CS_DIV64: tick_next[gi] = tap[1];
          STP_CS_DIV256: tick_next[gi] = tap[2];
          STP_CS_DIV1024: tick_next[gi] = tap[3];
          STP_CS_EXT_FALL: tick_next[gi] = ext_fall[gi];
          STP_CS_EXT_RISE: tick_next[gi] = ext_rise[gi];
        endcase
      end
    end
  endgenerate

  // Only whole-word accesses decode; others read zero and write nothing
  assign addr_ok = (hsize == 3'h2) && (haddr[1:0] == 2'h0);

  always_comb begin
    s_next = s_reg;
    s_next.tick = tick_next;
    s_next.ready = 1'b1;

    if (!s_reg.sync_hold) begin
      s_next.sh_rst = 1'b0;
      s_next.t0_rst = 1'b0;
    end

    if (s_reg.dp_wr) begin
      unique case (s_reg.dp_addr)
        `STP_OFS_SFIO: begin
          s_next.sync_hold = hwdata[`STP_BIT_HOLD];
          s_next.sh_rst = hwdata[`STP_BIT_SH_RST];
          s_next.t0_rst = hwdata[`STP_BIT_T0_RST];
        end
        `STP_OFS_CSEL: begin
          for (int i = 0; i < `STP_NUM_TIMERS; i++) begin
            s_next.csel[i*`STP_CS_W +: `STP_CS_W] =
              hwdata[i*`STP_CSEL_STRIDE +: `STP_CS_W];
          end
        end
        default: begin
        end
      endcase
    end

    s_next.dp_wr = 1'b0;
    if (hsel && hready && (htrans == `STP_HTRANS_NONSEQ)) begin
      s_next.dp_wr = hwrite && addr_ok;
      s_next.dp_addr = haddr[`STP_ADDR_W-1:0];
      if (!hwrite) begin
        // SFIO and CSEL reads see the state after any write now finishing
        s_next.rdata = `STP_RDATA_ZERO;
        if (addr_ok) begin
          unique case (haddr[`STP_ADDR_W-1:0])
            `STP_OFS_SFIO: begin
              s_next.rdata[`STP_BIT_HOLD] = s_next.sync_hold;
              s_next.rdata[`STP_BIT_T0_RST] = s_next.t0_rst;
              s_next.rdata[`STP_BIT_SH_RST] = s_next.sh_rst;
            end
            `STP_OFS_CSEL: begin
              for (int i = 0; i < `STP_NUM_TIMERS; i++) begin
                s_next.rdata[i*`STP_CSEL_STRIDE +: `STP_CS_W] =
                  s_next.csel[i*`STP_CS_W +: `STP_CS_W];
              end
            end
            `STP_OFS_STAT: begin
              s_next.rdata[`STP_DIV_W-1:0] = div_count;
              s_next.rdata[`STP_STAT_TICK_LSB +: `STP_NUM_TIMERS] =
                s_reg.tick;
              s_next.rdata[`STP_STAT_HOLD_BIT] =
                s_reg.sync_hold && (s_reg.sh_rst || s_reg.t0_rst);
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign hrdata = s_reg.rdata;
  assign hreadyout = s_reg.ready;
  assign hresp = `STP_HRESP_OKAY;
  assign timer_tick = s_reg.tick;
  assign timer0_divider_reset = s_reg.t0_rst;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic sfio_wr;
  assign sfio_wr = s_reg.dp_wr && (s_reg.dp_addr == `STP_OFS_SFIO);

  sequence s_sfio_write(logic hold_v, logic rst_v);
    sfio_wr && (hwdata[`STP_BIT_HOLD] == hold_v) &&
      (hwdata[`STP_BIT_SH_RST] == rst_v);
  endsequence

  sequence s_no_sfio_write;
    !sfio_wr;
  endsequence

  property p_hold_keeps;
    s_sfio_write(1'b1, 1'b1) ##1 s_no_sfio_write[*3] |->
      s_reg.sh_rst && s_reg.sync_hold;
  endproperty
  a_hold_keeps: assert property (p_hold_keeps)
    else $error("reset bit dropped while hold was set");

  property p_release_clears;
    s_reg.sync_hold && s_reg.sh_rst && s_reg.t0_rst ##0
      s_sfio_write(1'b0, 1'b0) |=> !s_reg.sh_rst && !s_reg.t0_rst;
  endproperty
  a_release_clears: assert property (p_release_clears)
    else $error("hold release did not clear both reset bits");

  property p_pulse_reset;
    s_sfio_write(1'b0, 1'b1) |=> s_reg.sh_rst ##1 !s_reg.sh_rst;
  endproperty
  a_pulse_reset: assert property (p_pulse_reset)
    else $error("shared reset bit not cleared after one cycle");

  property p_cs_off;
    s_reg.csel[`STP_CS_W-1:0] == STP_CS_OFF |=> !timer_tick[0];
  endproperty
  a_cs_off: assert property (p_cs_off)
    else $error("stopped timer received a tick");

  property p_cs_sys;
    s_reg.csel[`STP_CS_W-1:0] == STP_CS_SYS |=> timer_tick[0];
  endproperty
  a_cs_sys: assert property (p_cs_sys)
    else $error("system clock select missed a cycle");

  property p_div8_tick;
    (s_reg.csel[`STP_CS_W-1:0] == STP_CS_DIV8) && tap[0] |=>
      timer_tick[0];
  endproperty
  a_div8_tick: assert property (p_div8_tick)
    else $error("divide-by-8 select did not follow its tap");

  property p_ext_rise;
    (s_reg.csel[`STP_CS_W-1:0] == STP_CS_EXT_RISE) |=>
      timer_tick[0] == $past(ext_rise[0]);
  endproperty
  a_ext_rise: assert property (p_ext_rise)
    else $error("rising edge select tick mismatch");

  // Ready comes up on the first edge after reset, so skip that edge
  property p_always_ready;
    !$past(rst) |-> hreadyout && (hresp == `STP_HRESP_OKAY);
  endproperty
  a_always_ready: assert property (p_always_ready)
    else $error("slave stalled or answered an error");

  property p_ext_fall;
    (s_reg.csel[`STP_CS_W-1:0] == STP_CS_EXT_FALL) |=>
      timer_tick[0] == $past(ext_fall[0]);
  endproperty
  a_ext_fall: assert property (p_ext_fall)
    else $error("falling edge select tick mismatch");

  property p_ext_rise_t2;
    (s_reg.csel[2*`STP_CS_W +: `STP_CS_W] == STP_CS_EXT_RISE) |=>
      timer_tick[2] == $past(ext_rise[2]);
  endproperty
  a_ext_rise_t2: assert property (p_ext_rise_t2)
    else $error("pin edge did not form the tick directly");

  property p_ext_fall_t2;
    (s_reg.csel[2*`STP_CS_W +: `STP_CS_W] == STP_CS_EXT_FALL) |=>
      timer_tick[2] == $past(ext_fall[2]);
  endproperty
  a_ext_fall_t2: assert property (p_ext_fall_t2)
    else $error("pin fall did not form the tick directly");

  property p_div64_t1;
    (s_reg.csel[`STP_CS_W +: `STP_CS_W] == STP_CS_DIV64) |=>
      timer_tick[1] == $past(tap[1]);
  endproperty
  a_div64_t1: assert property (p_div64_t1)
    else $error("divide-by-64 select did not follow its tap");

  property p_div256_t1;
    (s_reg.csel[`STP_CS_W +: `STP_CS_W] == STP_CS_DIV256) |=>
      timer_tick[1] == $past(tap[2]);
  endproperty
  a_div256_t1: assert property (p_div256_t1)
    else $error("divide-by-256 select did not follow its tap");

  property p_div1024_t1;
    (s_reg.csel[`STP_CS_W +: `STP_CS_W] == STP_CS_DIV1024) |=>
      timer_tick[1] == $past(tap[3]);
  endproperty
  a_div1024_t1: assert property (p_div1024_t1)
    else $error("divide-by-1024 select did not follow its tap");

  property p_off_t1;
    (s_reg.csel[`STP_CS_W +: `STP_CS_W] == STP_CS_OFF) |=>
      !timer_tick[1];
  endproperty
  a_off_t1: assert property (p_off_t1)
    else $error("stopped timer one received a tick");

  // A held prescaled timer must not advance while software configures it
  property p_hold_halts;
    s_reg.sync_hold && s_reg.sh_rst &&
      (s_reg.csel[`STP_CS_W-1:0] == STP_CS_DIV8) |=> !timer_tick[0];
  endproperty
  a_hold_halts: assert property (p_hold_halts)
    else $error("held timer advanced during configuration");

  sequence s_hold_release;
    s_reg.sync_hold && s_reg.sh_rst ##0 s_sfio_write(1'b0, 1'b0);
  endsequence

  property p_release_start;
    s_hold_release |=> (div_count == '0) ##1
      (div_count == `STP_DIV_W'(1));
  endproperty
  a_release_start: assert property (p_release_start)
    else $error("divider did not start from zero on release");

  property p_shared_restart;
    s_sfio_write(1'b0, 1'b1) |=> ##1 (div_count == '0);
  endproperty
  a_shared_restart: assert property (p_shared_restart)
    else $error("shared reset write did not restart the divider");

endmodule : stp_top

/* File: design/stp_params.svh */
// Purpose: constants of the shared timer prescaler
// Assumes: included by bare name; guard prevents double inclusion
// Notes: byte offsets are word aligned
`ifndef STP_PARAMS_SVH
`define STP_PARAMS_SVH

`define STP_CLK_PERIOD_NS 100
`define STP_NUM_TIMERS 3
`define STP_CS_W 3
`define STP_DIV_W 10
`define STP_NUM_TAPS 4
`define STP_ADDR_W 8

`define STP_OFS_SFIO 8'h00
`define STP_OFS_CSEL 8'h04
`define STP_OFS_STAT 8'h08

`define STP_BIT_HOLD 7
`define STP_BIT_T0_RST 1
`define STP_BIT_SH_RST 0

`define STP_CSEL_STRIDE 4
`define STP_STAT_HOLD_BIT 16
`define STP_STAT_TICK_LSB 12

`define STP_TAP8_MASK 10'h007
`define STP_TAP64_MASK 10'h03f
`define STP_TAP256_MASK 10'h0ff
`define STP_TAP1024_MASK 10'h3ff

`define STP_HTRANS_NONSEQ 2'h2
`define STP_HRESP_OKAY 1'h0
`define STP_RDATA_ZERO 32'h0000_0000

`endif

/* File: design/stp_pkg.sv */
// Purpose: types of the shared timer prescaler
// Assumes: constants come from stp_params.svh
// Notes: one state struct per module
`include "stp_params.svh"

package stp_pkg;

  typedef enum logic [2:0] {
    STP_CS_OFF = 3'h0,
    STP_CS_SYS = 3'h1,
    STP_CS_DIV8 = 3'h2,
    STP_CS_DIV64 = 3'h3,
    STP_CS_DIV256 = 3'h4,
    STP_CS_DIV1024 = 3'h5,
    STP_CS_EXT_FALL = 3'h6,
    STP_CS_EXT_RISE = 3'h7
  } stp_cs_e;

  typedef struct packed {
    logic [`STP_DIV_W-1:0] count;
  } stp_div_s;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
  } stp_sync_s;

  typedef struct packed {
    logic sync_hold;
    logic t0_rst;
    logic sh_rst;
    logic [`STP_NUM_TIMERS*`STP_CS_W-1:0] csel;
    logic [`STP_NUM_TIMERS-1:0] tick;
    logic dp_wr;
    logic [`STP_ADDR_W-1:0] dp_addr;
    logic ready;
    logic [31:0] rdata;
  } stp_top_s;

endpackage : stp_pkg

/* File: design/stp_divider.sv */
// Purpose: free-running 10-bit system clock divider with four taps
// Assumes: clear is a level from the shared reset bit
// Notes: taps are one-cycle enables, never gated clocks
`timescale 1ns/1ps
`include "stp_params.svh"

module stp_divider
  import stp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  output logic [`STP_NUM_TAPS-1:0] tap,
  output logic [`STP_DIV_W-1:0] count
);

  stp_div_s s_reg;
  stp_div_s s_next;

  always_comb begin
    s_next = s_reg;
    if (clear) begin
      s_next.count = '0;
    end else begin
      s_next.count = s_reg.count + `STP_DIV_W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Held at zero while cleared, so no tap fires during a hold
  assign tap[0] = !clear && ((s_reg.count & `STP_TAP8_MASK) == `STP_TAP8_MASK);
  assign tap[1] = !clear && ((s_reg.count & `STP_TAP64_MASK) == `STP_TAP64_MASK);
  assign tap[2] = !clear && ((s_reg.count & `STP_TAP256_MASK) == `STP_TAP256_MASK);
  assign tap[3] = !clear && ((s_reg.count & `STP_TAP1024_MASK) == `STP_TAP1024_MASK);
  assign count = s_reg.count;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_tap8_spacing;
    tap[0] |=> (!tap[0])[*7];
  endproperty
  a_tap8_spacing: assert property (p_tap8_spacing)
    else $error("divide-by-8 tap fired early");

  property p_tap_nesting;
    (tap[3] |-> tap[2]) and (tap[2] |-> tap[1]) and (tap[1] |-> tap[0]);
  endproperty
  a_tap_nesting: assert property (p_tap_nesting)
    else $error("slower tap fired without faster tap");

  property p_clear_restart;
    clear |=> (count == '0) || clear;
  endproperty
  a_clear_restart: assert property (p_clear_restart)
    else $error("divider did not restart on clear");

endmodule : stp_divider

/* File: design/stp_ext_sync.sv */
// Purpose: count pin synchroniser and edge detector
// Assumes: pin is asynchronous to clk
// Notes: latch, then two flops, then edge compare
`timescale 1ns/1ps
`include "stp_params.svh"

module stp_ext_sync
  import stp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  output logic rise,
  output logic fall
);

  logic pin_lat;
  stp_sync_s s_reg;
  stp_sync_s s_next;

  // Transparent while clk is high; a pin change while clk is low waits one more cycle
  always_latch begin
    if (clk) begin
      pin_lat <= pin;
    end
  end

  always_comb begin
    s_next = s_reg;
    s_next.sync1 = pin_lat;
    s_next.sync2 = s_reg.sync1;
    s_next.prev = s_reg.sync2;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rise = s_reg.sync2 && !s_reg.prev;
  assign fall = !s_reg.sync2 && s_reg.prev;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_single_edge;
    (rise |=> !rise) and (fall |=> !fall) and !(rise && fall);
  endproperty
  a_single_edge: assert property (p_single_edge)
    else $error("edge detector pulse longer than one cycle");

endmodule : stp_ext_sync

/* File: dv/stp_pin_model.sv */
// Purpose: far-side source driving the three count pins
// Assumes: half period is given in system clock cycles, at least 2
// Notes: pins change mid-cycle and hold still whenever stopped
`timescale 1ns/1ps

module stp_pin_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] run,
  input wire logic [7:0] half,
  output logic [2:0] pin
);
  int cnt;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      pin <= 3'h0;
    end else if (run != 3'h0) begin
      // Each phase lasts several clocks so the sampler never aliases
      if (cnt >= half - 1) begin
        cnt <= 0;
        pin <= #37 pin ^ run;
      end else begin
        cnt <= cnt + 1;
      end
    end else begin
      cnt <= 0;
    end
  end
endmodule : stp_pin_model

/* File: dv/shared_timer_prescaler_test.sv */
// Purpose: self-checking bench for the shared timer prescaler
// Assumes: zero-wait AHB-Lite slave, registers at 0x00, 0x04, 0x08
// Notes: ticks are sampled 1 ns after the edge, once settled; bus reads sample at the edge
`timescale 1ns/1ps
`include "stp_params.svh"

module shared_timer_prescaler_test
  import stp_pkg::*;
;
  logic clk, rst, hsel, hwrite, hready, hreadyout, hresp, t0_rst;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0] htrans;
  logic [2:0] hsize, pins, ticks, run;
  logic [7:0] half;
  int err_count, total_checks, n, dv;

  assign hready = hreadyout;

  stp_top u_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .external_count_pin(pins), .timer_tick(ticks),
    .timer0_divider_reset(t0_rst));

  stp_pin_model u_pins (.clk(clk), .rst(rst), .run(run), .half(half),
    .pin(pins));

  always #50 clk = ~clk;

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= `STP_HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= 3'h2;
    // Only the watchdog ends a wait; a stalled slave must fail the run
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task step;
    @(posedge clk);
    #1;
  endtask : step

  // Cycles until the next tick of timer i, never fewer than one
  task gap(input int i, input int lim, output int n);
    n = 0;
    do begin step; n++; end while (ticks[i] !== 1'b1 && n < lim);
  endtask : gap

  task test_regs;
    bus(1'b0, 8'h00, 0, v); chk(v, 0);
    bus(1'b0, 8'h04, 0, v); chk(v, 0);
    chk(hresp, `STP_HRESP_OKAY);
    chk(hreadyout, 1);
    repeat (20) begin step; chk(ticks, 0); end
    wr(8'h04, 32'h0000_0501);
    wr(8'h0c, 32'hffff_ffff);
    bus(1'b0, 8'h04, 0, v); chk(v, 32'h0000_0501);
    bus(1'b0, 8'h0c, 0, v); chk(v, 0);
    repeat (5) begin step; chk(ticks[0], 1); end
    wr(8'h04, 0);
    $display("test_regs done");
  endtask : test_regs

  task test_div;
    for (int c = 2; c <= 5; c++) begin
      dv = (c == 2) ? 8 : (c == 3) ? 64 : (c == 4) ? 256 : 1024;
      wr(8'h04, 32'(c) << 4);
      wr(8'h00, 32'h01);
      gap(1, dv + 4, n); chk(n <= dv + 2, 1);
      gap(1, 1100, n); chk(n, dv);
    end
    wr(8'h04, 32'h0000_0020);
    wr(8'h00, 32'h01);
    gap(1, 20, n); chk(n >= 8 && n <= 10, 1);
    wr(8'h04, 0);
    $display("test_div done");
  endtask : test_div

  task test_hold;
    wr(8'h04, 32'h0000_0202);
    wr(8'h00, 32'h83);
    bus(1'b0, 8'h00, 0, v); chk(v, 32'h83);
    bus(1'b0, 8'h08, 0, v); chk(v, 32'h0001_0000);
    chk(t0_rst, 1);
    repeat (30) begin step; chk(ticks, 0); end
    wr(8'h00, 0);
    bus(1'b0, 8'h00, 0, v); chk(v, 0);
    chk(t0_rst, 0);
    n = 0;
    repeat (40) begin
      step;
      chk(ticks[0], ticks[2]);
      n += int'(ticks[0] === 1'b1);
    end
    chk(n, 5);
    wr(8'h00, 32'h01);
    bus(1'b0, 8'h00, 0, v);
    bus(1'b0, 8'h00, 0, v); chk(v, 0);
    wr(8'h04, 0);
    $display("test_hold done");
  endtask : test_hold

  task test_ext;
    for (int c = 7; c >= 6; c--) begin
      wr(8'h04, (32'(c) << 8) | 32'(c));
      repeat (3) step;
      @(posedge clk);
      run <= 3'h5;
      if (c == 7) @(posedge pins[2]);
      else @(negedge pins[2]);
      gap(2, 10, n); chk(n >= 3 && n <= 4, 1);
      gap(2, 20, n); chk(n, 10);
      chk(ticks[0], 1);
      @(posedge clk);
      run <= 3'h0;
      repeat (4) step;
    end
    wr(8'h04, 0);
    $display("test_ext done");
  endtask : test_ext

  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 0;
    run = 3'h0;
    half = 8'd5;
    err_count = 0;
    total_checks = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    test_regs;
    test_div;
    test_hold;
    test_ext;
    finish_test;
  end

  // Whole run needs well under 10000 cycles
  initial begin
    #3000000;
    err_count++;
    finish_test;
  end
endmodule : shared_timer_prescaler_test
